// >>> logic/disp_cmd_pkg.sv
// Notes on behaviour
// - The enter-idle command (39h, no parameter) switches on idle mode.
// - In idle mode only the top bit of each red, green and blue input counts.
// - Each colour top bit selects its primary, mixing to eight colours.
// - An enter-idle command while already idle changes nothing.
// - The pixel-format command (3Ah) takes one byte; bits 7 and 3 stay zero.
// - Bits 6:4 set the video format, bits 2:0 the command one; default 70h.
// - A format field of 101, 110 or 111 means 16, 18 or 24 bits per pixel.
// - These commands work in normal mode and sleep-in, not in partial mode.
// - Write-continue (3Ch) stores pixels from where the last write stopped.
// - Set-tear-line (44h) takes two bytes, upper line byte first.
// - After set-tear-line the tear output fires when the scan hits the line.
// - The 16-bit tear line resets to zero.
// - In sleep-in the tear output is held low.
// - Scan line 0 is the first vertical-sync line; counting runs on.
package disp_cmd_pkg;
    localparam logic [7:0] CMD_FRAME_WRITE = 8'h2c;
    localparam logic [7:0] CMD_ENTER_IDLE = 8'h39;
    localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3a;
    localparam logic [7:0] CMD_WRITE_CONTINUE = 8'h3c;
    localparam logic [7:0] CMD_SET_TEAR_LINE = 8'h44;
    localparam logic [15:0] ADDR_PIXEL_FORMAT = 16'h3a00;
    localparam logic [15:0] ADDR_TEAR_UPPER = 16'h4400;
    localparam logic [15:0] ADDR_TEAR_LOWER = 16'h4401;
    localparam logic [7:0] PIXEL_FORMAT_RESET = 8'h70;
    localparam logic [15:0] TEAR_LINE_RESET = 16'h0000;
    localparam int VIDEO_FMT_LSB = 4;
    localparam int FIELD_W = 3;
    localparam logic [2:0] FMT_16BPP = 3'h5;
    localparam logic [2:0] FMT_18BPP = 3'h6;
    localparam logic [2:0] FMT_24BPP = 3'h7;
    localparam logic [4:0] BPP_16 = 5'h10;
    localparam logic [4:0] BPP_18 = 5'h12;
    localparam logic [4:0] BPP_24 = 5'h18;
    localparam int PIXEL_W = 24;
    localparam int FIFO_DEPTH = 4;
    localparam int RED_MSB = 23;
    localparam int GREEN_MSB = 15;
    localparam int BLUE_MSB = 7;
endpackage

// >>> logic/pixel_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// Valid/ready word stream between the command logic and the pixel FIFO.
interface pixel_stream_if #(parameter int WIDTH = 24);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> logic/pixel_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO; ready on the fill side drops when it is full.
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    pixel_stream_if.snk fill,
    pixel_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshakes; valid comes straight from the occupancy count, ready from the count and flush.
    assign fill.ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
    assign drain.valid = (count_reg != '0);
    assign drain.data = mem[rd_ptr_reg];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // Storage has no reset; only the pointers and the count need a defined state.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= fill.data;
        end
    end

    // Pointer and count bookkeeping.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    property p_no_overfill;
        @(posedge clk) disable iff (!rstn)
        (count_reg == (AW+1)'(DEPTH)) |-> !fill.ready;
    endproperty
    a_no_overfill: assert property (p_no_overfill)
        else $error("FIFO accepts data while full.");
endmodule
`default_nettype wire

// >>> logic/disp_cmd_core.sv
`timescale 1ns/1ps
`default_nettype none
// Command interpreter for idle mode, pixel format, write-continue and tear.
module disp_cmd_core #(
    parameter int ADDR_W = 22,
    parameter int FIFO_DEPTH = disp_cmd_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic param_valid,
    input wire logic [7:0] param_data,
    input wire logic pixel_valid,
    input wire logic [23:0] pixel_data,
    output logic pixel_ready,
    output logic mem_wr_en,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [23:0] mem_wr_data,
    input wire logic mem_ready,
    input wire logic sleep_in,
    input wire logic partial_mode,
    input wire logic frame_start,
    input wire logic line_start,
    input wire logic dot_valid,
    input wire logic [23:0] dot_in,
    output logic [23:0] dot_out,
    output logic idle_mode,
    output logic [2:0] video_pixel_format,
    output logic [2:0] command_pixel_format,
    output logic [4:0] video_bpp,
    output logic [4:0] command_bpp,
    output logic [15:0] tear_line_value,
    output logic [15:0] current_scan_line,
    output logic tear_sync_out,
    output logic cmd_refused
);
    // -------------------------------------------------------------------
    // Command sequencing
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        WAIT_CMD, FMT_PARAM, TEAR_UPPER, TEAR_LOWER, STREAM
    } cmd_state_type;

    cmd_state_type state_reg;
    cmd_state_type state_next;
    logic cmd_take;
    logic [7:0] pixel_format_select_reg;
    logic [7:0] tear_line_upper_reg;
    logic [15:0] tear_line_reg;
    logic tear_enable_reg;
    logic idle_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [15:0] line_reg;
    logic tear_out_reg;
    logic [23:0] dot_reg;
    logic flush;

    pixel_stream_if #(.WIDTH(disp_cmd_pkg::PIXEL_W)) fill_bus ();
    pixel_stream_if #(.WIDTH(disp_cmd_pkg::PIXEL_W)) drain_bus ();

    // Partial mode shuts this command set out; the refusal is visible.
    assign cmd_take = cmd_valid && !partial_mode;
    assign flush = soft_reset;

    // Decode a three-bit format field into bits per pixel.
    function automatic logic [4:0] fmt_bpp(input logic [2:0] f);
        logic [4:0] b;
        b = disp_cmd_pkg::BPP_24;
        unique case (f)
            disp_cmd_pkg::FMT_16BPP: b = disp_cmd_pkg::BPP_16;
            disp_cmd_pkg::FMT_18BPP: b = disp_cmd_pkg::BPP_18;
            disp_cmd_pkg::FMT_24BPP: b = disp_cmd_pkg::BPP_24;
            default: b = disp_cmd_pkg::BPP_24;
        endcase
        return b;
    endfunction

    // Next state: any command ends the current stream or parameter phase.
    always_comb begin
        state_next = state_reg;
        if (cmd_take) begin
            unique case (cmd_code)
                disp_cmd_pkg::CMD_PIXEL_FORMAT: state_next = FMT_PARAM;
                disp_cmd_pkg::CMD_SET_TEAR_LINE: state_next = TEAR_UPPER;
                disp_cmd_pkg::CMD_FRAME_WRITE: state_next = STREAM;
                disp_cmd_pkg::CMD_WRITE_CONTINUE: state_next = STREAM;
                default: state_next = WAIT_CMD;
            endcase
        end else if (cmd_valid) begin
            state_next = WAIT_CMD;
        end else if (param_valid) begin
            unique case (state_reg)
                FMT_PARAM: state_next = WAIT_CMD;
                TEAR_UPPER: state_next = TEAR_LOWER;
                TEAR_LOWER: state_next = WAIT_CMD;
                WAIT_CMD, STREAM: state_next = state_reg;
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= WAIT_CMD;
        end else if (soft_reset) begin
            state_reg <= WAIT_CMD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Refusal pulse for commands arriving during partial mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_refused <= 1'b0;
        end else begin
            cmd_refused <= cmd_valid && partial_mode;
        end
    end

    // -------------------------------------------------------------------
    // Mode and format registers
    // -------------------------------------------------------------------
    // Idle is a set-only flag here; a repeat enter-idle rewrites the same 1.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_reg <= 1'b0;
        end else if (soft_reset) begin
            idle_reg <= 1'b0;
        end else if (cmd_take && cmd_code == disp_cmd_pkg::CMD_ENTER_IDLE) begin
            idle_reg <= 1'b1;
        end
    end

    // Format byte; bits 7 and 3 are forced to zero whatever the host sends.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pixel_format_select_reg <= disp_cmd_pkg::PIXEL_FORMAT_RESET;
        end else if (soft_reset) begin
            pixel_format_select_reg <= disp_cmd_pkg::PIXEL_FORMAT_RESET;
        end else if (state_reg == FMT_PARAM && param_valid && !cmd_valid) begin
            pixel_format_select_reg <= param_data & 8'h77;
        end
    end

    assign idle_mode = idle_reg;
    assign video_pixel_format = pixel_format_select_reg[
        disp_cmd_pkg::VIDEO_FMT_LSB +: disp_cmd_pkg::FIELD_W];
    assign command_pixel_format =
        pixel_format_select_reg[0 +: disp_cmd_pkg::FIELD_W];
    assign video_bpp = fmt_bpp(video_pixel_format);
    assign command_bpp = fmt_bpp(command_pixel_format);

    // -------------------------------------------------------------------
    // Tear line
    // -------------------------------------------------------------------
    // Upper byte comes first and is parked until the lower one arrives, so
    // the comparator never sees a half-updated line number.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tear_line_upper_reg <= 8'h00;
            tear_line_reg <= disp_cmd_pkg::TEAR_LINE_RESET;
            tear_enable_reg <= 1'b0;
        end else if (soft_reset) begin
            tear_line_upper_reg <= 8'h00;
            tear_line_reg <= disp_cmd_pkg::TEAR_LINE_RESET;
            tear_enable_reg <= 1'b0;
        end else if (param_valid && !cmd_valid) begin
            if (state_reg == TEAR_UPPER) begin
                tear_line_upper_reg <= param_data;
            end
            if (state_reg == TEAR_LOWER) begin
                tear_line_reg <= {tear_line_upper_reg, param_data};
                tear_enable_reg <= 1'b1;
            end
        end
    end

    // Line counter: frame start marks line 0, each line start adds one.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_reg <= 16'h0000;
        end else if (frame_start) begin
            line_reg <= 16'h0000;
        end else if (line_start) begin
            line_reg <= line_reg + 16'h0001;
        end
    end

    // Registered pad output; sleep wins over a match.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tear_out_reg <= 1'b0;
        end else begin
            tear_out_reg <= tear_enable_reg && !sleep_in
                            && line_reg == tear_line_reg;
        end
    end

    assign tear_line_value = tear_line_reg;
    assign current_scan_line = line_reg;
    assign tear_sync_out = tear_out_reg;

    // -------------------------------------------------------------------
    // Frame memory write path
    // -------------------------------------------------------------------
    // Only the stream state lets pixels in; a new command closes the gate
    // in the same cycle it appears, before any stray pixel is accepted.
    assign fill_bus.valid = pixel_valid && state_reg == STREAM && !cmd_valid;
    assign fill_bus.data = pixel_data;
    assign pixel_ready = fill_bus.ready && state_reg == STREAM
                         && !cmd_valid;
    assign drain_bus.ready = mem_ready;

    pixel_fifo #(
        .WIDTH(disp_cmd_pkg::PIXEL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .flush(flush),
        .fill(fill_bus),
        .drain(drain_bus)
    );

    // Write address: frame write restarts at zero, continue keeps counting.
    // Words still in the FIFO drain after the stream ends; they were taken
    // before the closing command and belong to that stream.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_reg <= '0;
        end else if (soft_reset) begin
            addr_reg <= '0;
        end else if (cmd_take && cmd_code == disp_cmd_pkg::CMD_FRAME_WRITE) begin
            addr_reg <= '0;
        end else if (drain_bus.valid && mem_ready) begin
            addr_reg <= addr_reg + 1'b1;
        end
    end

    // Memory write strobe and data registered from the FIFO head.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_wr_en <= 1'b0;
            mem_wr_addr <= '0;
            mem_wr_data <= 24'h000000;
        end else begin
            mem_wr_en <= drain_bus.valid && mem_ready;
            mem_wr_addr <= addr_reg;
            mem_wr_data <= drain_bus.data;
        end
    end

    // -------------------------------------------------------------------
    // Idle colour reduction
    // -------------------------------------------------------------------
    // Spreading each top bit over its lane gives full-on or off primaries.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dot_reg <= 24'h000000;
        end else if (dot_valid) begin
            if (idle_reg) begin
                dot_reg <= {{8{dot_in[disp_cmd_pkg::RED_MSB]}},
                            {8{dot_in[disp_cmd_pkg::GREEN_MSB]}},
                            {8{dot_in[disp_cmd_pkg::BLUE_MSB]}}};
            end else begin
                dot_reg <= dot_in;
            end
        end
    end

    assign dot_out = dot_reg;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_idle_enter;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && !partial_mode && !soft_reset
         && cmd_code == disp_cmd_pkg::CMD_ENTER_IDLE) |=> idle_mode;
    endproperty
    a_idle_enter: assert property (p_idle_enter)
        else $error("Enter-idle did not set idle mode.");

    property p_idle_colour;
        @(posedge clk) disable iff (!rstn)
        (idle_mode && dot_valid && !soft_reset) |=>
        dot_out == {{8{$past(dot_in[23])}}, {8{$past(dot_in[15])}},
                    {8{$past(dot_in[7])}}};
    endproperty
    a_idle_colour: assert property (p_idle_colour)
        else $error("Idle dot colour is not the top-bit primary.");

    property p_idle_repeat;
        @(posedge clk) disable iff (!rstn)
        (idle_mode && cmd_valid && !soft_reset
         && cmd_code == disp_cmd_pkg::CMD_ENTER_IDLE) |=>
        $stable(pixel_format_select_reg) && $stable(tear_line_value)
        && idle_mode;
    endproperty
    a_idle_repeat: assert property (p_idle_repeat)
        else $error("Repeated enter-idle changed state.");

    property p_format_write;
        @(posedge clk) disable iff (!rstn)
        (state_reg == FMT_PARAM && param_valid && !cmd_valid && !soft_reset)
        |=> video_pixel_format == $past(param_data[6:4])
            && command_pixel_format == $past(param_data[2:0])
            && pixel_format_select_reg[7] == 1'b0
            && pixel_format_select_reg[3] == 1'b0;
    endproperty
    a_format_write: assert property (p_format_write)
        else $error("Pixel format byte not stored as sent.");

    property p_partial_block;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && partial_mode && !soft_reset) |=>
        $stable(idle_mode) && cmd_refused && state_reg == WAIT_CMD;
    endproperty
    a_partial_block: assert property (p_partial_block)
        else $error("Command acted on in partial mode.");

    property p_continue_addr;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && !partial_mode && !soft_reset && !drain_bus.valid
         && cmd_code == disp_cmd_pkg::CMD_WRITE_CONTINUE) |=>
        $stable(addr_reg) && state_reg == STREAM;
    endproperty
    a_continue_addr: assert property (p_continue_addr)
        else $error("Write-continue moved the write address.");

    property p_tear_pair;
        @(posedge clk) disable iff (!rstn)
        (state_reg == TEAR_UPPER && param_valid && !cmd_valid && !soft_reset)
        ##1 (param_valid && !cmd_valid && !soft_reset) |=>
        tear_line_value == {$past(param_data, 2), $past(param_data)};
    endproperty
    a_tear_pair: assert property (p_tear_pair)
        else $error("Tear line bytes paired in the wrong order.");

    property p_tear_fire;
        @(posedge clk) disable iff (!rstn)
        (tear_enable_reg && !sleep_in && line_reg == tear_line_reg)
        |=> tear_sync_out;
    endproperty
    a_tear_fire: assert property (p_tear_fire)
        else $error("Tear output missed its line.");

    property p_tear_sleep;
        @(posedge clk) disable iff (!rstn)
        sleep_in |=> !tear_sync_out;
    endproperty
    a_tear_sleep: assert property (p_tear_sleep)
        else $error("Tear output high during sleep-in.");

    property p_line_zero;
        @(posedge clk) disable iff (!rstn)
        frame_start |=> current_scan_line == 16'h0000;
    endproperty
    a_line_zero: assert property (p_line_zero)
        else $error("Frame start did not give line 0.");

    property p_stream_end;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && cmd_code != disp_cmd_pkg::CMD_FRAME_WRITE
         && cmd_code != disp_cmd_pkg::CMD_WRITE_CONTINUE)
        |-> !pixel_ready ##1 !pixel_ready;
    endproperty
    a_stream_end: assert property (p_stream_end)
        else $error("Pixels still taken after a new command.");
endmodule
`default_nettype wire

// >>> sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor: changes strobes on falling edges only, and flips any
// bus it releases so that a stale value can never pass for a good one.
module host_model (
    input wire logic clk,
    input wire logic pixel_ready,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic param_valid,
    output logic [7:0] param_data,
    output logic pixel_valid,
    output logic [23:0] pixel_data
);
    // Quiet bus from time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        param_valid = 1'b0;
        param_data = 8'h00;
        pixel_valid = 1'b0;
        pixel_data = 24'h000000;
    end

    // A command is a one-cycle strobe; it also ends any pixel stream.
    task automatic cmd(input logic [7:0] c);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code = ~c;
    endtask

    // Parameter bytes go out in the order the caller gives them.
    task automatic prm(input logic [7:0] p);
        @(negedge clk);
        param_valid = 1'b1;
        param_data = p;
        @(negedge clk);
        param_valid = 1'b0;
        param_data = ~p;
    endtask

    // Two parameter bytes back to back, strobe held high across both.
    task automatic prm2(input logic [7:0] a, input logic [7:0] b);
        @(negedge clk);
        param_valid = 1'b1;
        param_data = a;
        @(negedge clk);
        param_data = b;
        @(negedge clk);
        param_valid = 1'b0;
        param_data = ~b;
    endtask

    // Word held until taken; ok stays low if the wait runs out.
    task automatic push(input logic [23:0] d, output logic ok);
        int n;
        @(negedge clk);
        pixel_valid = 1'b1;
        pixel_data = d;
        // Ready is judged at the falling edge, where it has settled, so the
        // word is known to be taken at the rising edge that follows.
        for (n = 0; n < 200 && pixel_ready !== 1'b1; n++) begin
            @(negedge clk);
        end
        ok = pixel_ready;
        @(negedge clk);
        pixel_valid = 1'b0;
        pixel_data = ~d;
    endtask
endmodule
`default_nettype wire

// >>> sim/display_idle_format_tear_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none
module display_idle_format_tear_cmds_test;
    logic clk, rstn, soft_reset, sleep_in, partial_mode, hold;
    logic frame_start, line_start, dot_valid, mem_ready = 1'b0;
    logic cmd_valid, param_valid, pixel_valid, pixel_ready, mem_wr_en;
    logic idle_mode, tear_sync_out, cmd_refused;
    logic [7:0] cmd_code, param_data;
    logic [23:0] dot_in, dot_out, pixel_data, mem_wr_data;
    logic [21:0] mem_wr_addr;
    logic [2:0] vfmt, cfmt, f, g;
    logic [7:0] u;
    logic [4:0] vbpp, cbpp;
    logic [15:0] tear_val, scan_line;
    logic [31:0] seed = 32'h5333;
    logic [23:0] exp_q[$];
    int mismatches, n_checks, exp_addr, k;

    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    host_model host_model_i (.clk(clk), .pixel_ready(pixel_ready),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .param_valid(param_valid), .param_data(param_data),
        .pixel_valid(pixel_valid), .pixel_data(pixel_data));
    disp_cmd_core disp_cmd_core_i (.clk(clk), .rstn(rstn),
        .soft_reset(soft_reset), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .param_valid(param_valid),
        .param_data(param_data), .pixel_valid(pixel_valid),
        .pixel_data(pixel_data), .pixel_ready(pixel_ready),
        .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .mem_ready(mem_ready),
        .sleep_in(sleep_in), .partial_mode(partial_mode),
        .frame_start(frame_start), .line_start(line_start),
        .dot_valid(dot_valid), .dot_in(dot_in), .dot_out(dot_out),
        .idle_mode(idle_mode), .video_pixel_format(vfmt),
        .command_pixel_format(cfmt), .video_bpp(vbpp),
        .command_bpp(cbpp), .tear_line_value(tear_val),
        .current_scan_line(scan_line), .tear_sync_out(tear_sync_out),
        .cmd_refused(cmd_refused));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] bpp(input logic [2:0] x);
        if (x == disp_cmd_pkg::FMT_16BPP) return disp_cmd_pkg::BPP_16;
        if (x == disp_cmd_pkg::FMT_18BPP) return disp_cmd_pkg::BPP_18;
        return disp_cmd_pkg::BPP_24;
    endfunction
    function automatic logic [23:0] idle_of(input logic [23:0] v);
        return {{8{v[23]}}, {8{v[15]}}, {8{v[7]}}};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic dot(input logic [23:0] v, input logic [23:0] e);
        @(negedge clk);
        dot_valid = 1'b1;
        dot_in = v;
        @(negedge clk);
        dot_valid = 1'b0;
        dot_in = ~v;
        check(dot_out, e);
    endtask
    task automatic pulse(input logic frame);
        @(negedge clk);
        frame_start = frame;
        line_start = ~frame;
        @(negedge clk);
        frame_start = 1'b0;
        line_start = 1'b0;
    endtask
    // Words are queued before they are offered, as the drain may be quick.
    task automatic send(input int n);
        logic ok;
        logic [23:0] d;
        for (int i = 0; i < n; i++) begin
            d = seed[23:0];
            exp_q.push_back(d);
            host_model_i.push(d, ok);
            if (ok !== 1'b1) begin
                mismatches++;
                final_report();
            end
        end
    endtask

    // Random memory back-pressure, stopped outright while hold is high.
    always @(negedge clk) begin
        seed <= lfsr(seed);
        mem_ready <= hold ? 1'b0 : seed[3];
    end
    // Every memory write must carry the next word at the next address; the
    // strobe is looked at on the falling edge, where it has settled.
    always @(negedge clk) begin
        if (mem_wr_en === 1'b1) begin
            check(mem_wr_addr, exp_addr);
            check(exp_q.size() > 0, 1);
            if (exp_q.size() > 0) check(mem_wr_data, exp_q.pop_front());
            exp_addr++;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rstn, soft_reset, sleep_in, partial_mode} = 4'h0;
        {frame_start, line_start, dot_valid, hold} = 4'h1;
        dot_in = 24'h000000;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        check(idle_mode, 0);
        check({1'b0, vfmt, 1'b0, cfmt}, disp_cmd_pkg::PIXEL_FORMAT_RESET);
        check(tear_val, disp_cmd_pkg::TEAR_LINE_RESET);
        dot(seed[23:0] | 24'h7f7f7f, seed[23:0] | 24'h7f7f7f);
        for (k = 4; k < 8; k++) begin
            f = k[2:0];
            g = 3'h5 + 3'(seed % 3);
            sleep_in = seed[2];
            host_model_i.cmd(disp_cmd_pkg::CMD_PIXEL_FORMAT);
            host_model_i.prm({1'b0, f, 1'b0, g});
            check({vfmt, cfmt}, {f, g});
            check({vbpp, cbpp}, {bpp(f), bpp(g)});
        end
        sleep_in = 1'b0;
        partial_mode = 1'b1;
        host_model_i.cmd(disp_cmd_pkg::CMD_PIXEL_FORMAT);
        check(cmd_refused, 1);
        host_model_i.prm(8'h55);
        partial_mode = 1'b0;
        check({vfmt, cfmt}, {f, g});
        host_model_i.cmd(disp_cmd_pkg::CMD_ENTER_IDLE);
        check(idle_mode, 1);
        for (k = 0; k < 4; k++) dot(seed[23:0], idle_of(seed[23:0]));
        host_model_i.cmd(disp_cmd_pkg::CMD_ENTER_IDLE);
        check({idle_mode, vfmt, cfmt}, {1'b1, f, g});
        host_model_i.cmd(disp_cmd_pkg::CMD_SET_TEAR_LINE);
        u = seed[15:8];
        host_model_i.prm(u);
        host_model_i.prm(8'hc3);
        check(tear_val, {u, 8'hc3});
        host_model_i.cmd(disp_cmd_pkg::CMD_SET_TEAR_LINE);
        host_model_i.prm(8'h00);
        host_model_i.cmd(8'h00);
        check(tear_val[7:0], 8'hc3);
        host_model_i.cmd(disp_cmd_pkg::CMD_SET_TEAR_LINE);
        host_model_i.prm2(8'h00, 8'h05);
        check(tear_val, 16'h0005);
        pulse(1'b1);
        check(scan_line, 0);
        for (k = 1; k < 6; k++) begin
            pulse(1'b0);
            check({scan_line, tear_sync_out}, {16'(k), 1'b0});
        end
        @(negedge clk);
        check(tear_sync_out, 1);
        sleep_in = 1'b1;
        repeat (2) @(negedge clk);
        check(tear_sync_out, 0);
        sleep_in = 1'b0;
        host_model_i.cmd(disp_cmd_pkg::CMD_FRAME_WRITE);
        send(4);
        @(negedge clk);
        check(pixel_ready, 0);
        hold = 1'b0;
        send(2);
        host_model_i.cmd(disp_cmd_pkg::CMD_WRITE_CONTINUE);
        send(4);
        repeat (40) @(negedge clk);
        check(exp_addr, 10);
        check(exp_q.size(), 0);
        host_model_i.cmd(disp_cmd_pkg::CMD_ENTER_IDLE);
        check(pixel_ready, 0);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        @(negedge clk);
        check({idle_mode, tear_val}, 0);
        check({1'b0, vfmt, 1'b0, cfmt}, disp_cmd_pkg::PIXEL_FORMAT_RESET);
        final_report();
    end
endmodule
`default_nettype wire
